// File: rtl/oscsu_params.svh
`ifndef OSCSU_PARAMS_SVH
`define OSCSU_PARAMS_SVH

// ------------------------------------------------------------
// register byte offsets on the bus
// ------------------------------------------------------------
`define OSCSU_A_CTRL 8'h00
`define OSCSU_A_CFG1 8'h04
`define OSCSU_A_KEY  8'h08
`define OSCSU_A_STAT 8'h0C

// unlock keys, written in this order to the key register
`define OSCSU_KEY1 32'h5A5A1234
`define OSCSU_KEY2 32'hA5A54321

// ------------------------------------------------------------
// clock control register fields
// ------------------------------------------------------------
`define OSCSU_CC_LOD  29:27
`define OSCSU_CC_RCD  26:24
`define OSCSU_CC_ARDY 22
`define OSCSU_CC_LMUL 18:16
`define OSCSU_CC_CUR  14:12
`define OSCSU_CC_NEW  10:8
`define OSCSU_CC_LOCK 5
`define OSCSU_CC_AEN  1
`define OSCSU_CC_SWR  0

// ------------------------------------------------------------
// configuration word fields
// ------------------------------------------------------------
`define OSCSU_C1_SRC  2:0
`define OSCSU_C1_AHW  5
`define OSCSU_C1_DRV  7:6
`define OSCSU_C1_PIN2 9
`define OSCSU_C2_LID  2:0
`define OSCSU_C2_LMUL 6:4
`define OSCSU_C2_LOD  18:16

// ------------------------------------------------------------
// status register fields
// ------------------------------------------------------------
`define OSCSU_ST_PRDY 0
`define OSCSU_ST_ARDY 1
`define OSCSU_ST_LOCK 2
`define OSCSU_ST_OPEN 3
`define OSCSU_ST_PCNT 13:4
`define OSCSU_ST_ACNT 25:16

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define OSCSU_OST_LAST  10'h3FF
`define OSCSU_WARM_LAST 10'h3FF
`define OSCSU_CLK_NS    8
`define OSCSU_LOCK_NS   2000
`define OSCSU_LOCK_CYC  ((`OSCSU_LOCK_NS + `OSCSU_CLK_NS - 1) / `OSCSU_CLK_NS)
`define OSCSU_LOCK_W    9
`define OSCSU_LID_DIV2  3'h1

`endif

// File: rtl/oscsu_pkg.sv
package oscsu_pkg;

    typedef enum logic [2:0] {
        SRC_RC     = 3'b000,
        SRC_RCPLL  = 3'b001,
        SRC_PRI    = 3'b010,
        SRC_PRIPLL = 3'b011,
        SRC_AUX    = 3'b100,
        SRC_LPRC   = 3'b101,
        SRC_RC16   = 3'b110,
        SRC_RCDIV  = 3'b111
    } oscsu_src_t;

    typedef enum logic [1:0] {
        DRV_DRIVEN = 2'b00,
        DRV_MED    = 2'b01,
        DRV_HIGH   = 2'b10,
        DRV_RSVD   = 2'b11
    } oscsu_drv_t;

    typedef enum logic [1:0] {
        KEY_LOCKED = 2'b00,
        KEY_HALF   = 2'b01,
        KEY_OPEN   = 2'b10
    } oscsu_key_t;

endpackage : oscsu_pkg

// File: rtl/oscsu_ctrl.sv
// What this block does
// - default source code 010 picks primary alone, 011 primary through the loop
// - drive mode picks high-gain crystal, medium-gain crystal or driven clock
// - drive mode codes: 10 high gain, 01 medium gain, 00 driven clock
// - loop output divider sits in control bits 29:27, writable, default from config
// - 10-bit start-up timer holds primary clock back for 1024 oscillator cycles
// - start-up timer counts only once valid oscillator edges are seen
// - full start-up timeout after power-on, brown-out and wake from sleep
// - start-up timeout covers both crystal modes and the secondary source
// - driven clock mode bypasses the start-up timer, with or without loop
// - crystal modes reserve the primary output pin for feedback while primary is the default or current source
// - driven clock disables feedback; output pin is I/O or bus clock
// - config bit 9 picks bus clock or digital I/O for a free output pin
// - config bit 5 is the hardware enable of the secondary source
// - control bit 1 starts secondary source and gives it both its pins
// - control register writes are blocked unless the unlock sequence came first
// - secondary warm-up counts to 1024 then sets ready in control bit 22
// - secondary source runs as long as its software enable and config bit 5 are both set
// - returning to a crystal or loop primary source repeats the start-up delay
// - rc output divider in control bits 26:24, undivided plus seven ratios
// - rc divided mode is active while current source reads 111
// - rc loop mode is active while current source reads 001
// - rc loop mode forces loop input divide-by-2, other loop settings stay
// - loop lock clears on input change, sets on lock or timer expiry
//
// Local design decisions: the APB interface to the registers and the register offsets.

`include "oscsu_params.svh"

module oscsu_ctrl (
    input  wire logic                 i_ref_clk,
    input  wire logic                 i_resetn,
    input  wire logic                 i_psel,
    input  wire logic                 i_penable,
    input  wire logic                 i_pwrite,
    input  wire logic [7:0]           i_paddr,
    input  wire logic [31:0]          i_pwdata,
    output logic      [31:0]          o_prdata,
    output logic                      o_pready,
    output logic                      o_pslverr,
    input  wire logic [31:0]          i_config_word_one,
    input  wire logic [31:0]          i_config_word_two,
    input  wire logic                 i_primary_pin_in,
    input  wire logic                 i_primary_amp_ok,
    input  wire logic                 i_aux_pin_in,
    input  wire logic                 i_aux_amp_ok,
    input  wire logic                 i_bor_restart,
    input  wire logic                 i_sleep_wake,
    input  wire logic                 i_loop_locked,
    output logic                      o_primary_clk_ready,
    output logic      [1:0]           o_primary_gain,
    output logic                      o_feedback_en,
    output logic                      o_pin2_peripheral_bus_clock_out,
    output logic                      o_pin2_gpio_avail,
    output logic                      o_aux_pins_osc,
    output logic                      o_aux_crystal_ready,
    output oscsu_pkg::oscsu_src_t     o_current_clock_source,
    output logic                      o_loop_lock_status,
    output logic      [2:0]           o_loop_in_div,
    output logic      [2:0]           o_loop_mult,
    output logic      [8:0]           o_loop_out_ratio,
    output logic      [8:0]           o_rc_div_ratio
);
    import oscsu_pkg::*;

    localparam logic [`OSCSU_LOCK_W-1:0] LOCK_LAST = `OSCSU_LOCK_W'(`OSCSU_LOCK_CYC - 1);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------

    // ratio table shared by the rc divider and the loop output divider;
    // note the jump from 64 straight to 256
    function automatic logic [8:0] div_ratio(input logic [2:0] code);
        logic [8:0] r;
        r = 9'h001;
        unique case (code)
            3'h0: r = 9'h001;
            3'h1: r = 9'h002;
            3'h2: r = 9'h004;
            3'h3: r = 9'h008;
            3'h4: r = 9'h010;
            3'h5: r = 9'h020;
            3'h6: r = 9'h040;
            3'h7: r = 9'h100;
        endcase
        return r;
    endfunction : div_ratio

    function automatic logic uses_loop(input oscsu_src_t s);
        return (s == SRC_RCPLL) || (s == SRC_PRIPLL);
    endfunction : uses_loop

    function automatic logic is_primary(input oscsu_src_t s);
        return (s == SRC_PRI) || (s == SRC_PRIPLL);
    endfunction : is_primary

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    oscsu_key_t       key_st;
    oscsu_src_t       cur_src;
    oscsu_src_t       new_src;
    logic [2:0]       lod;
    logic [2:0]       rcd;
    logic [2:0]       lmul;
    logic             aux_sw_en;
    logic             sw_req;
    logic [9:0]       pri_cnt;
    logic             pri_done;
    logic             pri_pin_q;
    logic [9:0]       aux_cnt;
    logic             aux_rdy;
    logic             aux_pin_q;
    logic             lock;
    logic [`OSCSU_LOCK_W-1:0] lock_cnt;

    // ------------------------------------------------------------
    // configuration decode
    // ------------------------------------------------------------
    oscsu_drv_t drv;
    oscsu_src_t cfg_src;
    logic       crystal;
    logic       pri_ok;
    logic       aux_on;
    logic       restart;

    assign drv     = oscsu_drv_t'(i_config_word_one[`OSCSU_C1_DRV]);
    assign cfg_src = oscsu_src_t'(i_config_word_one[`OSCSU_C1_SRC]);

    always_comb begin
        crystal = 1'b0;
        unique case (drv)
            DRV_HIGH:   crystal = 1'b1;
            DRV_MED:    crystal = 1'b1;
            DRV_DRIVEN: crystal = 1'b0;
            DRV_RSVD:   crystal = 1'b0;
        endcase
    end

    assign pri_ok  = !crystal || pri_done;
    assign aux_on  = i_config_word_one[`OSCSU_C1_AHW] && aux_sw_en;
    assign restart = i_bor_restart || i_sleep_wake;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    logic acc;
    logic wr;
    logic phase;
    logic sel_ctrl;
    logic sel_cfg1;
    logic sel_key;
    logic sel_stat;
    logic ctrl_wr;
    logic bad;

    assign acc      = i_psel && i_penable && o_pready;
    assign wr       = acc && i_pwrite;
    // access phase before the answer is given
    assign phase    = i_psel && i_penable && !o_pready;
    assign sel_ctrl = i_paddr == `OSCSU_A_CTRL;
    assign sel_cfg1 = i_paddr == `OSCSU_A_CFG1;
    assign sel_key  = i_paddr == `OSCSU_A_KEY;
    assign sel_stat = i_paddr == `OSCSU_A_STAT;
    assign ctrl_wr  = wr && sel_ctrl && (key_st == KEY_OPEN);

    always_comb begin
        bad = !(sel_ctrl || sel_cfg1 || sel_key || sel_stat);
        if (i_pwrite && (sel_cfg1 || sel_stat)) begin
            bad = 1'b1;
        end
        if (i_pwrite && sel_ctrl && (key_st != KEY_OPEN)) begin
            bad = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // unlock sequence
    // ------------------------------------------------------------
    // two keys back to back, good for one write
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            key_st <= KEY_LOCKED;
        end else if (wr) begin
            unique case (key_st)
                KEY_LOCKED: begin
                    if (sel_key && i_pwdata == `OSCSU_KEY1) begin
                        key_st <= KEY_HALF;
                    end
                end
                KEY_HALF: begin
                    if (sel_key && i_pwdata == `OSCSU_KEY2) begin
                        key_st <= KEY_OPEN;
                    end else begin
                        key_st <= KEY_LOCKED;
                    end
                end
                KEY_OPEN: key_st <= KEY_LOCKED;
                default:  key_st <= KEY_LOCKED;
            endcase
        end
    end

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    logic tgt_ready;
    logic sw_done;
    logic sw_start_pri;

    always_comb begin
        tgt_ready = 1'b1;
        if (is_primary(new_src)) begin
            tgt_ready = pri_ok;
        end else if (new_src == SRC_AUX) begin
            tgt_ready = aux_rdy;
        end
    end

    assign sw_done      = sw_req && tgt_ready;
    // new switch to primary restarts the start-up delay
    assign sw_start_pri = ctrl_wr && i_pwdata[`OSCSU_CC_SWR]
                          && is_primary(oscsu_src_t'(i_pwdata[`OSCSU_CC_NEW]));

    // runtime loop settings, defaults copied from config at reset
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            lod       <= i_config_word_two[`OSCSU_C2_LOD];
            lmul      <= i_config_word_two[`OSCSU_C2_LMUL];
            rcd       <= '0;
            aux_sw_en <= '0;
            new_src   <= cfg_src;
        end else if (ctrl_wr) begin
            lod       <= i_pwdata[`OSCSU_CC_LOD];
            lmul      <= i_pwdata[`OSCSU_CC_LMUL];
            rcd       <= i_pwdata[`OSCSU_CC_RCD];
            aux_sw_en <= i_pwdata[`OSCSU_CC_AEN];
            new_src   <= oscsu_src_t'(i_pwdata[`OSCSU_CC_NEW]);
        end
    end

    // current source starts from the configured default
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            cur_src <= cfg_src;
            sw_req  <= '0;
        end else begin
            if (sw_done) begin
                cur_src <= new_src;
                sw_req  <= '0;
            end
            // a fresh request wins over completion
            if (ctrl_wr && i_pwdata[`OSCSU_CC_SWR]) begin
                sw_req <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // primary start-up timer
    // ------------------------------------------------------------
    logic pri_edge;

    assign pri_edge = i_primary_pin_in && !pri_pin_q;

    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            pri_pin_q <= '0;
        end else begin
            pri_pin_q <= i_primary_pin_in;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn || restart || sw_start_pri) begin
            pri_cnt  <= '0;
            pri_done <= '0;
        // count only valid edges; crystal modes only
        end else if (!pri_done && crystal && i_primary_amp_ok && pri_edge) begin
            if (pri_cnt == `OSCSU_OST_LAST) begin
                pri_done <= 1'b1;
            end else begin
                pri_cnt <= pri_cnt + 10'h001;
            end
        end
    end

    // ------------------------------------------------------------
    // secondary warm-up
    // ------------------------------------------------------------
    logic aux_edge;

    assign aux_edge = i_aux_pin_in && !aux_pin_q;

    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            aux_pin_q <= '0;
        end else begin
            aux_pin_q <= i_aux_pin_in;
        end
    end

    // warm-up to 1024 then ready; timeout also covers secondary
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn || !aux_on || restart) begin
            aux_cnt <= '0;
            aux_rdy <= '0;
        end else if (!aux_rdy && i_aux_amp_ok && aux_edge) begin
            if (aux_cnt == `OSCSU_WARM_LAST) begin
                aux_rdy <= 1'b1;
            end else begin
                aux_cnt <= aux_cnt + 10'h001;
            end
        end
    end

    // ------------------------------------------------------------
    // loop lock status
    // ------------------------------------------------------------
    logic loop_in_ok;

    assign loop_in_ok = is_primary(cur_src) ? pri_ok : 1'b1;

    // clear on input change, set on lock or timer expiry
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn || sw_done || restart || !uses_loop(cur_src)) begin
            lock     <= '0;
            lock_cnt <= '0;
        end else if (!lock && loop_in_ok) begin
            if (i_loop_locked || lock_cnt == LOCK_LAST) begin
                lock <= 1'b1;
            end else begin
                lock_cnt <= lock_cnt + `OSCSU_LOCK_W'(1);
            end
        end
    end

    // ------------------------------------------------------------
    // register read and bus answer
    // ------------------------------------------------------------
    logic [31:0] ctrl_word;
    logic [31:0] stat_word;
    logic [31:0] next_prdata;

    always_comb begin
        ctrl_word                 = '0;
        ctrl_word[`OSCSU_CC_LOD]  = lod;
        ctrl_word[`OSCSU_CC_RCD]  = rcd;
        ctrl_word[`OSCSU_CC_ARDY] = aux_rdy;
        ctrl_word[`OSCSU_CC_LMUL] = lmul;
        ctrl_word[`OSCSU_CC_CUR]  = cur_src;
        ctrl_word[`OSCSU_CC_NEW]  = new_src;
        ctrl_word[`OSCSU_CC_LOCK] = lock;
        ctrl_word[`OSCSU_CC_AEN]  = aux_sw_en;
        ctrl_word[`OSCSU_CC_SWR]  = sw_req;
    end

    always_comb begin
        stat_word                 = '0;
        stat_word[`OSCSU_ST_PRDY] = pri_ok;
        stat_word[`OSCSU_ST_ARDY] = aux_rdy;
        stat_word[`OSCSU_ST_LOCK] = lock;
        stat_word[`OSCSU_ST_OPEN] = key_st == KEY_OPEN;
        stat_word[`OSCSU_ST_PCNT] = pri_cnt;
        stat_word[`OSCSU_ST_ACNT] = aux_cnt;
    end

    always_comb begin
        next_prdata = '0;
        if (!i_pwrite) begin
            if (sel_ctrl) begin
                next_prdata = ctrl_word;
            end else if (sel_cfg1) begin
                next_prdata = i_config_word_one;
            end else if (sel_stat) begin
                next_prdata = stat_word;
            end
        end
    end

    // one wait state: the answer comes in the second access cycle
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            o_pready  <= '0;
            o_pslverr <= '0;
            o_prdata  <= '0;
        end else begin
            o_pready  <= phase;
            o_pslverr <= phase && bad;
            o_prdata  <= phase ? next_prdata : '0;
        end
    end

    // ------------------------------------------------------------
    // pin and clock path outputs
    // ------------------------------------------------------------
    logic pri_selected;

    assign pri_selected = is_primary(cfg_src) || is_primary(cur_src);

    // crystal reserves the output pin when primary is default or current source; driven clock frees it
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            o_feedback_en     <= '0;
            o_pin2_peripheral_bus_clock_out  <= '0;
            o_pin2_gpio_avail <= '0;
            o_primary_gain    <= '0;
        end else begin
            o_feedback_en     <= pri_selected && crystal;
            o_primary_gain    <= crystal ? drv : DRV_DRIVEN;
            // bit low gives bus clock out, high gives digital I/O
            o_pin2_peripheral_bus_clock_out  <= !(pri_selected && crystal)
                                 && !i_config_word_one[`OSCSU_C1_PIN2];
            o_pin2_gpio_avail <= !(pri_selected && crystal)
                                 && i_config_word_one[`OSCSU_C1_PIN2];
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            o_primary_clk_ready <= '0;
            o_aux_pins_osc      <= '0;
            o_aux_crystal_ready <= '0;
            o_loop_lock_status  <= '0;
        end else begin
            o_primary_clk_ready <= pri_ok;
            o_aux_pins_osc      <= aux_on;
            o_aux_crystal_ready <= aux_rdy;
            o_loop_lock_status  <= lock;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            o_current_clock_source <= SRC_RC;
            o_loop_in_div          <= '0;
            o_loop_mult            <= '0;
            o_loop_out_ratio       <= '0;
            o_rc_div_ratio         <= '0;
        end else begin
            o_current_clock_source <= cur_src;
            // rc loop mode; forced input divide-by-2
            o_loop_in_div          <= (cur_src == SRC_RCPLL) ? `OSCSU_LID_DIV2
                                      : i_config_word_two[`OSCSU_C2_LID];
            o_loop_mult            <= lmul;
            o_loop_out_ratio       <= div_ratio(lod);
            // divider only in rc divided mode; ratio decode
            o_rc_div_ratio         <= (cur_src == SRC_RCDIV) ? div_ratio(rcd)
                                      : div_ratio('0);
        end
    end

endmodule : oscsu_ctrl

// File: tb/oscsu_ctrl_chk.sv
module oscsu_ctrl_chk (
    input wire logic                  i_ref_clk,
    input wire logic                  i_resetn,
    input wire logic                  i_psel,
    input wire logic                  i_penable,
    input wire logic                  i_pwrite,
    input wire logic [7:0]            i_paddr,
    input wire logic                  o_pready,
    input wire logic                  o_pslverr,
    input wire logic [31:0]           i_config_word_one,
    input wire logic                  i_primary_pin_in,
    input wire logic                  i_primary_amp_ok,
    input wire logic                  i_bor_restart,
    input wire logic                  i_sleep_wake,
    input wire logic                  o_primary_clk_ready,
    input wire logic                  o_feedback_en,
    input wire logic                  o_pin2_gpio_avail,
    input wire oscsu_pkg::oscsu_src_t o_current_clock_source,
    input wire logic [2:0]            o_loop_in_div,
    input wire logic [8:0]            o_rc_div_ratio
);
    timeunit 1ns;
    timeprecision 1ps;
    import oscsu_pkg::*;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);
    logic        pin_q;
    logic [15:0] edge_cnt;
    wire         xtal = i_config_word_one[7:6] inside {2'b01, 2'b10};
    always_ff @(posedge i_ref_clk) begin
        pin_q <= i_primary_pin_in;
    end
    // a few edges of slack: the design may resync the pin first
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn || i_bor_restart || i_sleep_wake) begin
            edge_cnt <= 16'h0000;
        end else if (i_primary_amp_ok && i_primary_pin_in && !pin_q) begin
            edge_cnt <= edge_cnt + 16'h0001;
        end
    end
    sequence s_access; i_psel && i_penable && !o_pready; endsequence
    sequence s_driven_held; (i_config_word_one[7:6] == 2'b00) [*3]; endsequence
    AST_ONE_WAIT: assert property (s_access |=> o_pready)
        else $error("bus answer late");
    AST_RO_WRITE: assert property (
        i_psel && i_penable && i_pwrite && o_pready && i_paddr == 8'h0C |-> o_pslverr)
        else $error("status write accepted");
    AST_PIN_RESERVED: assert property (o_feedback_en |-> !o_pin2_gpio_avail)
        else $error("feedback pin offered as io");
    AST_DRIVEN_PIN: assert property (
        s_driven_held |-> !o_feedback_en && o_pin2_gpio_avail == i_config_word_one[9])
        else $error("driven mode pin use wrong");
    AST_RESTART: assert property (
        i_bor_restart && xtal |-> ##[1:3] !o_primary_clk_ready)
        else $error("restart kept clock released");
    AST_OST_COUNT: assert property (
        $rose(o_primary_clk_ready) && xtal |-> edge_cnt >= 16'h03FC)
        else $error("primary released early");
    AST_RC_IDLE: assert property (
        $past(i_resetn) && o_current_clock_source != SRC_RCDIV |-> o_rc_div_ratio == 9'h001)
        else $error("rc divider active outside mode");
    AST_RC_LOOP: assert property (
        $past(i_resetn) && o_current_clock_source == SRC_RCPLL |-> o_loop_in_div == 3'h1)
        else $error("rc loop input divider not forced");
endmodule : oscsu_ctrl_chk

// File: tb/oscsu_xtal_model.sv
module oscsu_xtal_model (
    input  wire logic i_ref_clk,
    input  wire logic i_run,
    output logic      o_primary_pin,
    output logic      o_primary_amp_ok,
    output logic      o_aux_pin,
    output logic      o_aux_amp_ok
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] age = 8'h00;
    logic [2:0] ph = 3'h0;
    initial {o_primary_pin, o_primary_amp_ok, o_aux_pin, o_aux_amp_ok} = 4'h0;
    // amplitude builds up slowly; a stopped crystal leaves its pins still
    always @(posedge i_ref_clk) begin
        ph <= ph + 3'h1;
        age <= !i_run ? 8'h00 : (age == 8'hFF ? age : age + 8'h01);
        o_primary_amp_ok <= i_run && age > 8'h20;
        o_aux_amp_ok <= i_run && age > 8'h40;
        o_primary_pin <= i_run && ph[1];
        o_aux_pin <= i_run && ph[2];
    end
endmodule : oscsu_xtal_model

// File: tb/oscsu_ctrl_bench.sv
`include "oscsu_params.svh"
module oscsu_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import oscsu_pkg::*;
    logic       clk, rstn, psel, pen, pwr, pready, pslverr, err, bor, wake, run, locked;
    logic       p_pin, p_ok, a_pin, a_ok, p_rdy, a_rdy, lock_st, fb, peripheral_bus_clock, gpio, aux_osc;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, cfg1, cfg2;
    logic [2:0] idiv, lmul;
    logic [1:0] gain;
    logic [8:0] oratio, rratio;
    oscsu_src_t cur;
    int         err_count, cmp_count;
    localparam logic [8:0] RATIO [8] = '{9'h001, 9'h002, 9'h004, 9'h008,
                                         9'h010, 9'h020, 9'h040, 9'h100};
    oscsu_ctrl u_oscsu_ctrl (.i_ref_clk(clk), .i_resetn(rstn), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_config_word_one(cfg1),
        .i_config_word_two(cfg2), .i_primary_pin_in(p_pin), .i_primary_amp_ok(p_ok),
        .i_aux_pin_in(a_pin), .i_aux_amp_ok(a_ok), .i_bor_restart(bor), .i_sleep_wake(wake),
        .i_loop_locked(locked), .o_primary_clk_ready(p_rdy), .o_primary_gain(gain),
        .o_feedback_en(fb), .o_pin2_peripheral_bus_clock_out(peripheral_bus_clock), .o_pin2_gpio_avail(gpio),
        .o_aux_pins_osc(aux_osc), .o_aux_crystal_ready(a_rdy), .o_current_clock_source(cur),
        .o_loop_lock_status(lock_st), .o_loop_in_div(idiv), .o_loop_mult(lmul),
        .o_loop_out_ratio(oratio), .o_rc_div_ratio(rratio));
    oscsu_xtal_model u_oscsu_xtal_model (.i_ref_clk(clk), .i_run(run), .o_primary_pin(p_pin),
        .o_primary_amp_ok(p_ok), .o_aux_pin(a_pin), .o_aux_amp_ok(a_ok));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        #600000;
        err_count++;
        report_and_stop();
    end
    task report_and_stop();
        if (err_count == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : report_and_stop
    task chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            err_count++;
            $display("mismatch at %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, pwr, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        {rd, err} = {prdata, pslverr};
        {psel, pen} <= 2'b00;
    endtask : apb
    task wt(input bit aux);
        for (int n = 0; n < 12000 && (aux ? a_rdy : p_rdy) !== 1'b1; n++) @(posedge clk);
    endtask : wt
    task unlock_wr(input logic [2:0] lod, input logic [2:0] rcd, input logic [2:0] src);
        apb(1'b1, `OSCSU_A_KEY, `OSCSU_KEY1);
        apb(1'b1, `OSCSU_A_KEY, `OSCSU_KEY2);
        apb(1'b1, `OSCSU_A_CTRL, {2'b00, lod, rcd, 13'h0000, src, 6'h00, 2'b11});
        repeat (3) @(posedge clk);
    endtask : unlock_wr
    initial begin
        {rstn, psel, pen, pwr, bor, wake, run, locked, paddr, pwdata} = '0;
        // input divide code keeps the loop input in range
        {cfg1, cfg2, err_count, cmp_count} = {32'h000000A2, 32'h00050032, 64'h0};
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        repeat (50) @(posedge clk);
        chk(p_rdy, 0);
        chk({gain, fb}, 3'b101);
        chk(cur, SRC_PRI);
        chk({lmul, oratio}, 12'h620);
        run <= 1'b1;
        wt(0);
        chk(p_rdy, 1);
        for (int i = 0; i < 2; i++) begin
            {bor, wake} <= (i == 0) ? 2'b10 : 2'b01;
            @(posedge clk);
            {bor, wake} <= 2'b00;
            repeat (3) @(posedge clk);
            chk(p_rdy, 0);
            wt(0);
            chk(p_rdy, 1);
        end
        apb(1'b1, `OSCSU_A_CTRL, 32'h3F000701);
        chk(err, 1);
        apb(1'b1, `OSCSU_A_STAT, 32'h0);
        chk(err, 1);
        apb(1'b0, `OSCSU_A_CTRL, 32'h0);
        chk(rd[29:27], 3'h5);
        for (int k = 0; k < 8; k++) begin
            unlock_wr(k[2:0], k[2:0], SRC_RCDIV);
            chk(rratio, RATIO[k]);
            chk(oratio, RATIO[k]);
            chk(cur, SRC_RCDIV);
        end
        chk(aux_osc, 1);
        wt(1);
        apb(1'b0, `OSCSU_A_CTRL, 32'h0);
        chk(rd[22], 1);
        unlock_wr(3'h0, 3'h0, SRC_RCPLL);
        chk(idiv, 3'h1);
        chk(a_rdy, 1);
        repeat (260) @(posedge clk);
        chk(lock_st, 1);
        locked <= 1'b1;
        unlock_wr(3'h0, 3'h0, SRC_RCPLL);
        @(posedge clk) chk(lock_st, 1);
        {rstn, cfg1} <= {1'b0, 32'h00000202};
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        chk(p_rdy, 1);
        chk({gain, fb, gpio, peripheral_bus_clock}, 5'b00010);
        report_and_stop();
    end
endmodule : oscsu_ctrl_bench
bind oscsu_ctrl oscsu_ctrl_chk u_oscsu_ctrl_chk (.i_ref_clk, .i_resetn, .i_psel, .i_penable,
    .i_pwrite, .i_paddr, .o_pready, .o_pslverr, .i_config_word_one, .i_primary_pin_in,
    .i_primary_amp_ok, .i_bor_restart, .i_sleep_wake, .o_primary_clk_ready, .o_feedback_en,
    .o_pin2_gpio_avail, .o_current_clock_source, .o_loop_in_div, .o_rc_div_ratio);
